// *** src/bbce_exec.sv ***
/*
 * Execution unit for bit clear, bit set, relative branches, bit test with
 * skip and absolute call.
 * Assumes a combinational file read port addressed by rd_addr, a fetch unit
 * that honours pc_load and replaces the fetched word by a no-op on flush,
 * and a return stack that pushes push_addr on push_en.
 */
`timescale 1ns/100ps

// Functional notes
// - Bit clear zeroes bit b of file register, others kept, no flags.
// - Bit set forces selected bit to one, others kept, no flags.
// - Literal branch adds sign-extended 9-bit k to incremented PC.
// - Literal branch takes two cycles, prefetched instruction flushed.
// - Accumulator branch: next PC plus unsigned accumulator, two cycles.
// - Skip-if-clear discards next instruction as no-op when bit is zero.
// - Skip-if-set discards next instruction as no-op when bit is one.
// - Call pushes address after the call before the PC changes.
// - Call loads its 11-bit operand into PC bits 10 to 0.
// - Call fills PC bits 14 to 11 from latch bits 6 to 3.
// - Call takes two cycles and leaves status flags unchanged.
module bbce_exec
	import bbce_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic [OP_W-1:0] instr_op,
	input wire logic [FILE_W-1:0] file_addr,
	input wire logic [BITSEL_W-1:0] bit_sel,
	input wire logic [LIT_W-1:0] lit_k,
	input wire logic [PC_W-1:0] pc_incr,
	input wire logic [DATA_W-1:0] accum,
	input wire logic [BANK_W-1:0] bank_sel,
	input wire logic [LATCH_W-1:0] pc_upper_latch,
	output logic [DADDR_W-1:0] rd_addr,
	input wire logic [DATA_W-1:0] rd_data,
	output logic wr_en,
	output logic [DADDR_W-1:0] wr_addr,
	output logic [DATA_W-1:0] wr_data,
	output logic pc_load,
	output logic [PC_W-1:0] pc_target,
	output logic flush,
	output logic push_en,
	output logic [PC_W-1:0] push_addr
);

	// ****************************************
	// State
	// ****************************************
	bbce_state_t state_q;
	bbce_state_t state_d;
	logic wr_en_q;
	logic wr_en_d;
	logic [DADDR_W-1:0] wr_addr_q;
	logic [DADDR_W-1:0] wr_addr_d;
	logic [DATA_W-1:0] wr_data_q;
	logic [DATA_W-1:0] wr_data_d;
	logic pc_load_q;
	logic pc_load_d;
	logic [PC_W-1:0] pc_target_q;
	logic [PC_W-1:0] pc_target_d;
	logic flush_q;
	logic flush_d;
	logic push_en_q;
	logic push_en_d;
	logic [PC_W-1:0] push_addr_q;
	logic [PC_W-1:0] push_addr_d;

	logic [DATA_W-1:0] bit_mask;
	logic tested_bit;
	logic [PC_W-1:0] br_offset;
	logic [PC_W-1:0] acc_offset;
	logic accept;
	logic op_clear;
	logic op_set;
	logic op_br_lit;
	logic op_br_acc;
	logic op_skip_clr;
	logic op_skip_set;
	logic op_call;
	logic skip_taken;
	logic two_cycle;
	logic [PC_W-1:0] call_target;

	// ****************************************
	// Operand decode
	// ****************************************
	// The full data address joins the bank with the 7-bit operand.
	assign rd_addr = {bank_sel, file_addr};
	assign bit_mask = DATA_W'(1) << bit_sel;
	assign tested_bit = rd_data[bit_sel];
	assign br_offset = {{(PC_W-BRLIT_W){lit_k[BRLIT_SIGN]}},
		lit_k[BRLIT_W-1:0]};
	assign acc_offset = {{(PC_W-DATA_W){1'b0}}, accum};

	// The second cycle of a two-cycle operation refuses new work.
	assign instr_ready = (state_q == BBCE_IDLE);
	assign accept = instr_valid && instr_ready;

	// ****************************************
	// Operation decode
	// ****************************************
	// Every strobe is qualified by the take, so a refused offer does nothing.
	always_comb
	begin
		op_clear = 1'b0;
		op_set = 1'b0;
		op_br_lit = 1'b0;
		op_br_acc = 1'b0;
		op_skip_clr = 1'b0;
		op_skip_set = 1'b0;
		op_call = 1'b0;
		if (accept)
		begin
			case (instr_op)
				OP_BIT_CLEAR:
				begin
					op_clear = 1'b1;
				end
				OP_BIT_SET:
				begin
					op_set = 1'b1;
				end
				OP_BRANCH_LIT:
				begin
					op_br_lit = 1'b1;
				end
				OP_BRANCH_ACC:
				begin
					op_br_acc = 1'b1;
				end
				OP_SKIP_CLEAR:
				begin
					op_skip_clr = 1'b1;
				end
				OP_SKIP_SET:
				begin
					op_skip_set = 1'b1;
				end
				OP_CALL:
				begin
					op_call = 1'b1;
				end
				// The spare code is taken and has no effect.
				default:
				begin
					op_call = 1'b0;
				end
			endcase
		end
	end

	// The call target joins the latch field with the 11-bit operand.
	assign call_target = {pc_upper_latch[LATCH_CALL_MSB:LATCH_CALL_LSB],
		lit_k[CALL_LO_MSB:0]};
	// A skip costs a second cycle only when its test succeeds.
	assign skip_taken = (op_skip_clr && !tested_bit)
		|| (op_skip_set && tested_bit);
	assign two_cycle = op_br_lit || op_br_acc || skip_taken || op_call;

	// ****************************************
	// Sequencer
	// ****************************************
	// The second cycle runs the flushed slot as a no-op and takes no new
	// work, which is what makes these operations two cycles long.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			BBCE_IDLE:
			begin
				if (two_cycle)
				begin
					state_d = BBCE_SECOND;
				end
			end
			BBCE_SECOND:
			begin
				state_d = BBCE_IDLE;
			end
			default:
			begin
				state_d = BBCE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= BBCE_IDLE;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// File register write port
	// ****************************************
	// Only the addressed bit changes; the rest of the byte is written back
	// as read. No status flag port exists, so no flag can be touched.
	always_comb
	begin
		wr_en_d = 1'b0;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		if (op_clear)
		begin
			wr_en_d = 1'b1;
			wr_addr_d = rd_addr;
			wr_data_d = rd_data & ~bit_mask;
		end
		else if (op_set)
		begin
			wr_en_d = 1'b1;
			wr_addr_d = rd_addr;
			wr_data_d = rd_data | bit_mask;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_en_q <= 1'b0;
			wr_addr_q <= DADDR_RST;
			wr_data_q <= DATA_RST;
		end
		else if (clk_en)
		begin
			wr_en_q <= wr_en_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
		end
	end

	// ****************************************
	// Program counter and flush
	// ****************************************
	// Every two-cycle operation flushes the prefetched word; branches and
	// calls also load a new program counter in that same cycle.
	always_comb
	begin
		pc_load_d = 1'b0;
		pc_target_d = pc_target_q;
		flush_d = two_cycle;
		if (op_br_lit)
		begin
			pc_load_d = 1'b1;
			pc_target_d = pc_incr + br_offset;
		end
		else if (op_br_acc)
		begin
			pc_load_d = 1'b1;
			pc_target_d = pc_incr + acc_offset;
		end
		else if (op_call)
		begin
			pc_load_d = 1'b1;
			pc_target_d = call_target;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pc_load_q <= 1'b0;
			pc_target_q <= PC_RST;
			flush_q <= 1'b0;
		end
		else if (clk_en)
		begin
			pc_load_q <= pc_load_d;
			pc_target_q <= pc_target_d;
			flush_q <= flush_d;
		end
	end

	// ****************************************
	// Return stack push
	// ****************************************
	// The return address is the one that stood before the call changed it.
	always_comb
	begin
		push_en_d = 1'b0;
		push_addr_d = push_addr_q;
		if (op_call)
		begin
			push_en_d = 1'b1;
			push_addr_d = pc_incr;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			push_en_q <= 1'b0;
			push_addr_q <= PC_RST;
		end
		else if (clk_en)
		begin
			push_en_q <= push_en_d;
			push_addr_q <= push_addr_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wr_en = wr_en_q;
	assign wr_addr = wr_addr_q;
	assign wr_data = wr_data_q;
	assign pc_load = pc_load_q;
	assign pc_target = pc_target_q;
	assign flush = flush_q;
	assign push_en = push_en_q;
	assign push_addr = push_addr_q;

endmodule

// *** src/bbce_pkg.sv ***
/*
 * Shared constants for the bit, branch and call execution unit.
 * Assumes the core supplies one decoded operation at a time.
 */
package bbce_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int PC_W = 15;
	localparam int FILE_W = 7;
	localparam int BANK_W = 6;
	localparam int DADDR_W = BANK_W + FILE_W;
	localparam int DATA_W = 8;
	localparam int BITSEL_W = 3;
	localparam int LIT_W = 11;
	localparam int BRLIT_W = 9;
	localparam int LATCH_W = 7;
	localparam int OP_W = 3;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CALL_LO_MSB = 10;
	localparam int LATCH_CALL_MSB = 6;
	localparam int LATCH_CALL_LSB = 3;
	localparam int BRLIT_SIGN = 8;

	// ****************************************
	// Operation codes
	// ****************************************
	localparam logic [OP_W-1:0] OP_BIT_CLEAR = 3'h0;
	localparam logic [OP_W-1:0] OP_BIT_SET = 3'h1;
	localparam logic [OP_W-1:0] OP_BRANCH_LIT = 3'h2;
	localparam logic [OP_W-1:0] OP_BRANCH_ACC = 3'h3;
	localparam logic [OP_W-1:0] OP_SKIP_CLEAR = 3'h4;
	localparam logic [OP_W-1:0] OP_SKIP_SET = 3'h5;
	localparam logic [OP_W-1:0] OP_CALL = 3'h6;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;
	localparam logic [DADDR_W-1:0] DADDR_RST = 13'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [0:0] {
		BBCE_IDLE = 1'b0,
		BBCE_SECOND = 1'b1
	} bbce_state_t;

endpackage

// *** tb/bbce_exec_assertions.sv ***
/* Checker for bbce_exec, bound to it.
 * Assumes clk_en stays high. */
`timescale 1ns/100ps
module bbce_exec_assertions
	import bbce_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic wr_en,
	input wire logic pc_load,
	input wire logic flush,
	input wire logic push_en,
	input wire logic [2:0] instr_op,
	input wire logic [2:0] bit_sel,
	input wire logic [6:0] file_addr,
	input wire logic [6:0] pc_upper_latch,
	input wire logic [5:0] bank_sel,
	input wire logic [7:0] accum,
	input wire logic [7:0] rd_data,
	input wire logic [7:0] wr_data,
	input wire logic [10:0] lit_k,
	input wire logic [12:0] rd_addr,
	input wire logic [12:0] wr_addr,
	input wire logic [14:0] pc_incr,
	input wire logic [14:0] pc_target,
	input wire logic [14:0] push_addr
);
	logic t;
	logic sb;
	logic tc;
	logic sk;
	logic [12:0] ba;
	logic [14:0] sx, ct;
	assign t = clk_en & instr_valid & instr_ready;
	assign sb = rd_data[bit_sel];
	assign tc = t && (instr_op inside {3'h2, 3'h3, 3'h6});
	assign sk = t && ((instr_op == 3'h4 && !sb) || (instr_op == 3'h5 && sb));
	assign ba = {bank_sel, file_addr};
	assign sx = {{6{lit_k[8]}}, lit_k[8:0]};
	assign ct = {pc_upper_latch[6:3], lit_k};
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_gap;
		!instr_ready ##1 instr_ready;
	endsequence
	a_clear_bit: assert property (t && instr_op == 0 |=> wr_en &&
		wr_data == ($past(rd_data) & ~(8'h01 << $past(bit_sel))))
		else $error("bit clear result wrong");
	a_set_bit: assert property (t && instr_op == 1 |=> wr_en &&
		wr_data == ($past(rd_data) | (8'h01 << $past(bit_sel))))
		else $error("bit set result wrong");
	a_bank_addr: assert property (t && instr_op < 2 |=>
		wr_addr == $past(ba)) else $error("write address wrong");
	a_branch_lit: assert property (t && instr_op == 2 |=>
		pc_load && flush && pc_target == $past(pc_incr) + $past(sx))
		else $error("literal branch target wrong");
	a_two_cycle: assert property (tc |=> s_gap)
		else $error("two cycle timing wrong");
	a_read_addr: assert property (rd_addr == ba)
		else $error("read address wrong");
	a_branch_acc: assert property (t && instr_op == 3 |=> pc_load &&
		pc_target == $past(pc_incr) + $past(accum))
		else $error("accumulator branch target wrong");
	a_skip_clear: assert property (t && instr_op == 4 |=>
		flush == !$past(sb)) else $error("skip if clear wrong");
	a_skip_set: assert property (t && instr_op == 5 |=>
		flush == $past(sb)) else $error("skip if set wrong");
	a_skip_gap: assert property (sk |=> s_gap)
		else $error("skip timing wrong");
	a_call_push: assert property (t && instr_op == 6 |=> push_en &&
		pc_load && push_addr == $past(pc_incr)) else $error("push wrong");
	a_call_target: assert property (t && instr_op == 6 |=>
		pc_target == $past(ct)) else $error("call target wrong");
endmodule
bind bbce_exec bbce_exec_assertions i_chk (.*);

// *** tb/tb_bbce_exec.sv ***
/* Self-checking bench for bbce_exec.
 * Assumes the checker is bound; clk_en is held high. */
`timescale 1ns/100ps
module tb_bbce_exec
	import bbce_pkg::*;
;
	logic clock = 1'h0, arst_n = 1'h0, clk_en = 1'h1, instr_valid = 1'h0;
	logic [2:0] instr_op = '0, bit_sel = '0;
	logic [6:0] file_addr = 7'h15, pc_upper_latch = '0;
	logic [5:0] bank_sel = 6'h2a;
	logic [7:0] accum = '0, rd_data = '0, wr_data;
	logic [10:0] lit_k = '0;
	logic [14:0] pc_incr = '0, pc_target, push_addr;
	logic instr_ready, wr_en, pc_load, flush, push_en;
	logic [12:0] rd_addr, wr_addr;
	int miscompares = 0, cmp_count = 0;
	bbce_exec i_dut (.*);
	initial forever #25 clock = ~clock;
	task chk(input logic [31:0] g, e);
		cmp_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task finish_test;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Offers one operation at the current edge and returns after the take.
	task go(input logic [2:0] o, input logic [7:0] d);
		instr_op <= o;
		rd_data <= d;
		instr_valid <= 1'h1;
		@(posedge clock);
		instr_valid <= 1'h0;
		#1;
	endtask
	task t_bits;
		for (int b = 0; b < 8; b++)
		begin
			@(posedge clock);
			bit_sel <= 3'(b);
			go(OP_BIT_CLEAR, 8'ha5);
			chk({wr_en, wr_data}, 9'h1a5 & ~(9'h001 << b));
			chk(wr_addr, 13'h1515);
			chk(rd_addr, 13'h1515);
			@(posedge clock);
			go(OP_BIT_SET, 8'h5a);
			chk({wr_en, wr_data}, 9'h15a | (9'h001 << b));
		end
		$display("t_bits done");
	endtask
	task t_branch;
		@(posedge clock);
		lit_k <= 11'h100;
		pc_incr <= 15'h0005;
		go(OP_BRANCH_LIT, 8'h00);
		chk(pc_target, 15'h7f05);
		chk({pc_load, flush, instr_ready}, 3'h6);
		@(posedge clock);
		lit_k <= 11'h0ff;
		pc_incr <= 15'h7ff0;
		go(OP_BRANCH_LIT, 8'h00);
		chk(pc_target, 15'h00ef);
		@(posedge clock);
		accum <= 8'hff;
		pc_incr <= 15'h0010;
		go(OP_BRANCH_ACC, 8'h00);
		chk({pc_load, instr_ready, pc_target}, 17'h1010f);
		$display("t_branch done");
	endtask
	task t_skip;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clock);
			bit_sel <= 3'h7;
			go(i[1] ? OP_SKIP_SET : OP_SKIP_CLEAR, {i[0], {7{~i[0]}}});
			chk({flush, instr_ready}, {i[0] == i[1], i[0] != i[1]});
		end
		$display("t_skip done");
	endtask
	task t_call;
		@(posedge clock);
		lit_k <= 11'h7ff;
		pc_upper_latch <= 7'h78;
		pc_incr <= 15'h1234;
		go(OP_CALL, 8'h00);
		chk(push_addr, 15'h1234);
		chk({push_en, pc_load, instr_ready}, 3'h6);
		chk(pc_target, 15'h7fff);
		@(posedge clock);
		lit_k <= 11'h555;
		pc_upper_latch <= 7'h07;
		#1;
		chk(instr_ready, 1'h1);
		@(posedge clock);
		go(OP_CALL, 8'h00);
		chk(pc_target, 15'h0555);
		$display("t_call done");
	endtask
	initial
	begin
		repeat (8) @(posedge clock);
		arst_n <= 1'h1;
		t_bits;
		t_branch;
		t_skip;
		t_call;
		finish_test;
	end
	initial
	begin
		#100000;
		miscompares++;
		finish_test;
	end
endmodule
